// file: acs_checker.sv
// concurrent checks on the controller-to-amplifier pin link
`timescale 1ns/10ps
`default_nettype none
module acs_checker #(
	parameter int RST_HOLD_CYCLES  = 200,
	parameter int START_CYCLES     = 200,
	parameter int PDN_OFF_CYCLES   = 100,
	parameter int PDN_START_CYCLES = 80,
	parameter int ERR_HOLD_CYCLES  = 300
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       reset_n,
	input  wire logic       power_down_n,
	input  wire logic       backend_error_n,
	input  wire logic [2:0] input_format_sel,
	input  wire logic [1:0] gain_sel,
	input  wire logic       bclk,
	input  wire logic       fclk,
	input  wire logic       stage_enable,
	input  wire logic       bridge_low
);
	// saturating run lengths; 16 bits cover the shortened counts only
	logic [15:0] rst_lo, rst_hi, pdn_lo, pdn_hi, err_lo, brg_hi;
	logic [7:0]  bits;
	logic        bclk_d, fclk_d, fr_seen;
	function automatic logic [15:0] run(input logic on, input logic [15:0] c);
		return on ? ((c == 16'hffff) ? c : c + 16'h1) : 16'h0;
	endfunction
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{rst_lo, rst_hi, pdn_lo, pdn_hi, err_lo, brg_hi} <= '0;
			{bits, bclk_d, fclk_d, fr_seen} <= '0;
		end else begin
			rst_lo <= run(!reset_n, rst_lo);
			rst_hi <= run(reset_n, rst_hi);
			pdn_lo <= run(!power_down_n, pdn_lo);
			pdn_hi <= run(power_down_n, pdn_hi);
			err_lo <= run(!backend_error_n, err_lo);
			brg_hi <= run(bridge_low, brg_hi);
			bclk_d <= bclk;
			fclk_d <= fclk;
			if (fclk && !fclk_d) begin
				fr_seen <= 1'b1;
				bits <= 8'h0;
			end else if (bclk && !bclk_d) begin
				bits <= bits + 8'h1;
			end
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_bclk_per_frame: assert property (fclk && !fclk_d && fr_seen |-> bits inside {32, 48, 64})
		else $error("bit clocks per frame out of range");
	a_frame_edge_align: assert property ($changed(fclk) |-> !bclk && ($past(bclk) || $past(bclk, 2)))
		else $error("frame edge away from falling bit clock");
	a_reset_width: assert property ($rose(reset_n) |-> rst_lo >= RST_HOLD_CYCLES)
		else $error("reset pulse too short");
	a_reset_stage_off: assert property ($fell(reset_n) |-> ##[1:10] !stage_enable)
		else $error("stage still on after reset");
	a_start_delay: assert property ($rose(stage_enable) |-> rst_hi >= START_CYCLES && pdn_hi >= PDN_START_CYCLES)
		else $error("stage started too early");
	a_pdn_off_delay: assert property ($fell(stage_enable) && reset_n && backend_error_n |-> pdn_lo >= PDN_OFF_CYCLES)
		else $error("stage dropped before power-down delay");
	a_pdn_width: assert property ($rose(power_down_n) |-> pdn_lo >= 100)
		else $error("power-down pulse too short");
	a_err_width: assert property ($rose(backend_error_n) |-> err_lo >= 35)
		else $error("error pulse too short");
	a_err_response: assert property ($fell(backend_error_n) && reset_n |-> ##[1:35] bridge_low && !stage_enable)
		else $error("bridges not forced low after error");
	a_err_hold: assert property ($fell(bridge_low) |-> brg_hi >= ERR_HOLD_CYCLES && backend_error_n)
		else $error("bridges released early or with error active");
	a_strap_frozen: assert property (reset_n && $past(reset_n) |-> $stable({input_format_sel, gain_sel}))
		else $error("straps moved while out of reset");
	c_reset_release: cover property ($rose(reset_n));
	c_pdn_off: cover property ($fell(stage_enable) && !power_down_n);
	c_err_recover: cover property ($fell(bridge_low) && reset_n);
endmodule // acs_checker
`default_nettype wire

// file: acs_device.sv
// amplifier end: reset, power-down, error recovery, strap latch and mute ramp
`timescale 1ns/10ps
`default_nettype none
module acs_device
	import acs_pkg::*;
#(
	parameter int START_CYCLES     = acs_pkg::START_CYC,
	parameter int PDN_OFF_CYCLES   = acs_pkg::PDN_OFF_CYC,
	parameter int PDN_START_CYCLES = acs_pkg::PDN_START_CYC,
	parameter int ERR_HOLD_CYCLES  = acs_pkg::ERR_HOLD_CYC
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	acs_if.dev               pins,
	output logic             stage_enable,
	output logic             bridge_low,
	output logic      [10:0] volume,
	output logic      [4:0]  gain_db,
	output logic      [2:0]  data_format,
	output logic             format_reserved,
	output logic             ratio_ok,
	output logic      [4:0]  step_frames
);
	import acs_pkg::*;

	typedef struct packed {
		acs_dev_e    state;
		logic [24:0] cnt;
		logic        rst_q;
		logic        bclk_q;
		logic        fclk_q;
		logic [12:0] frame_cyc;
		logic [6:0]  bit_cnt;
		logic [4:0]  step_frames;
		logic [4:0]  frame_in_step;
		logic [10:0] volume;
		logic [2:0]  fmt;
		logic        fmt_reserved;
		logic [4:0]  gain_db;
		logic        ratio_ok;
		logic        stage_en;
		logic        bridge_low;
	} acs_dev_s;

	acs_dev_s   r;
	acs_dev_s   next_r;
	logic [10:0] sin;
	logic       s_rst_n;
	logic       s_pdn_n;
	logic       s_err_n;
	logic       s_mute_n;
	logic       s_bclk;
	logic       s_fclk;
	logic [2:0] s_fmt;
	logic [1:0] s_gain;
	logic       fclk_rise;
	logic [10:0] target;

	// every pin is asynchronous to clk, so all inputs but serial_audio_in go through two flops
	acs_sync #(
		.W (11)
	) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       ({pins.reset_n, pins.power_down_n, pins.backend_error_n, pins.mute_n,
			pins.bclk, pins.fclk, pins.input_format_sel, pins.gain_sel}),
		.q       (sin)
	);

	assign s_rst_n  = sin[10];
	assign s_pdn_n  = sin[9];
	assign s_err_n  = sin[8];
	assign s_mute_n = sin[7];
	assign s_bclk   = sin[6];
	assign s_fclk   = sin[5];
	assign s_fmt    = sin[4:2];
	assign s_gain   = sin[1:0];
	assign fclk_rise = s_fclk && !r.fclk_q;
	assign target = s_mute_n ? 11'(RAMP_STEPS) : 11'h000;

	always_comb begin
		next_r = r;
		next_r.rst_q = s_rst_n;
		next_r.bclk_q = s_bclk;
		next_r.fclk_q = s_fclk;
		if (r.cnt != '1) begin
			next_r.cnt = r.cnt + 25'h1;
		end
		if (r.frame_cyc != '1) begin
			next_r.frame_cyc = r.frame_cyc + 13'h1;
		end
		if (s_bclk && !r.bclk_q && r.bit_cnt != '1) begin
			next_r.bit_cnt = r.bit_cnt + 7'h1;
		end
		if (fclk_rise) begin
			next_r.frame_cyc = 13'h0000;
			next_r.bit_cnt = 7'h00;
			// a ratio outside the BITS_MIN..BITS_MAX range is reported, not corrected
			next_r.ratio_ok = (r.bit_cnt >= 7'(BITS_MIN)) && (r.bit_cnt <= 7'(BITS_MAX));
			if (r.frame_cyc < 13'(QUAD_MAX_CYC)) begin
				next_r.step_frames = STEP_QUAD;
			end else if (r.frame_cyc < 13'(DBL_MAX_CYC)) begin
				next_r.step_frames = STEP_DBL;
			end else begin
				next_r.step_frames = STEP_NORM;
			end
			if (r.frame_in_step + 5'h01 >= r.step_frames) begin
				next_r.frame_in_step = 5'h00;
				if (r.volume > target) begin
					next_r.volume = r.volume - 11'h001;
				end else if (r.volume < target) begin
					next_r.volume = r.volume + 11'h001;
				end
			end else begin
				next_r.frame_in_step = r.frame_in_step + 5'h01;
			end
		end

		if (s_err_n == 1'b0 && r.state != D_RESET && r.state != D_ERR_HOLD
			&& r.state != D_ERR_WAIT) begin
			// three edges from pin to output keeps well inside the limit
			next_r.state = D_ERR_HOLD;
			next_r.stage_en = 1'b0;
			next_r.bridge_low = 1'b1;
			next_r.cnt = 25'h0;
		end else begin
			case (r.state)
				D_RESET: begin
					next_r.stage_en = 1'b0;
					next_r.bridge_low = 1'b1;
					next_r.volume = 11'h000;
				end
				D_START: begin
					if (r.cnt >= 25'(START_CYCLES - 1)) begin
						next_r.state = D_RUN;
						next_r.stage_en = 1'b1;
						next_r.bridge_low = 1'b0;
					end
				end
				D_RUN: begin
					if (!s_pdn_n) begin
						next_r.state = D_PDN_DRAIN;
						next_r.cnt = 25'h0;
					end
				end
				D_PDN_DRAIN: begin
					if (s_pdn_n) begin
						next_r.state = D_RUN;
					end else if (r.cnt >= 25'(PDN_OFF_CYCLES - 1)) begin
						next_r.state = D_PDN_OFF;
						next_r.stage_en = 1'b0;
					end
				end
				D_PDN_OFF: begin
					if (s_pdn_n) begin
						next_r.state = D_PDN_START;
						next_r.cnt = 25'h0;
					end
				end
				D_PDN_START: begin
					if (!s_pdn_n) begin
						next_r.state = D_PDN_OFF;
					end else if (r.cnt >= 25'(PDN_START_CYCLES - 1)) begin
						next_r.state = D_RUN;
						next_r.stage_en = 1'b1;
					end
				end
				D_ERR_HOLD: begin
					if (r.cnt >= 25'(ERR_HOLD_CYCLES - 1)) begin
						// recovery is only tried once the error line is back high
						if (s_err_n) begin
							next_r.state = D_RUN;
							next_r.stage_en = 1'b1;
							next_r.bridge_low = 1'b0;
						end else begin
							next_r.state = D_ERR_WAIT;
						end
					end
				end
				D_ERR_WAIT: begin
					if (s_err_n) begin
						next_r.state = D_RUN;
						next_r.stage_en = 1'b1;
						next_r.bridge_low = 1'b0;
					end
				end
				default: begin
					next_r.state = D_RESET;
				end
			endcase
		end

		if (!s_rst_n) begin
			next_r.state = D_RESET;
			next_r.stage_en = 1'b0;
			next_r.bridge_low = 1'b1;
			next_r.volume = 11'h000;
			next_r.cnt = 25'h0;
		end else if (!r.rst_q) begin
			// straps are caught once here; later pin changes are ignored
			next_r.fmt = s_fmt;
			next_r.fmt_reserved = (s_fmt != FMT_RJ16) && (s_fmt != FMT_RJ18)
				&& (s_fmt != FMT_RJ20) && (s_fmt != FMT_RJ24)
				&& (s_fmt != FMT_I2S) && (s_fmt != FMT_LJ);
			next_r.gain_db = 5'(6 * s_gain);
			next_r.state = D_START;
			next_r.cnt = 25'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			r <= '0;
			r.state <= D_RESET;
			r.bridge_low <= 1'b1;
			r.step_frames <= STEP_NORM;
		end else begin
			r <= next_r;
		end
	end

	assign pins.stage_enable = r.stage_en;
	assign pins.bridge_low   = r.bridge_low;
	assign stage_enable      = r.stage_en;
	assign bridge_low        = r.bridge_low;
	assign volume            = r.volume;
	assign gain_db           = r.gain_db;
	assign data_format       = r.fmt;
	assign format_reserved   = r.fmt_reserved;
	assign ratio_ok          = r.ratio_ok;
	assign step_frames       = r.step_frames;
endmodule // acs_device
`default_nettype wire

// file: acs_host.sv
// controller end: wishbone registers driving reset, straps, pins and audio clocks
`timescale 1ns/10ps
`default_nettype none
module acs_host
	import acs_pkg::*;
#(
	parameter int RST_HOLD_CYCLES = acs_pkg::RST_HOLD_CYC,
	parameter int BITS_PER_FRAME  = acs_pkg::BITS_MAX,
	parameter int HALF_BCLK       = acs_pkg::BCLK_HALF
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	acs_if.host              pins,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             irq
);
	import acs_pkg::*;

	typedef struct packed {
		acs_host_e   state;
		logic [24:0] cnt;
		logic        ctrl_pdn;
		logic        ctrl_mute;
		logic        ctrl_err;
		logic [2:0]  fmt_reg;
		logic [1:0]  gain_reg;
		logic [2:0]  status;
		logic [2:0]  mask;
		logic        stage_q;
		logic        ack;
		logic [31:0] dat;
		logic        irq;
		logic        reset_n;
		logic        pdn_n;
		logic        err_n;
		logic [6:0]  pdn_cnt;
		logic [5:0]  err_cnt;
		logic [2:0]  fmt;
		logic [1:0]  gain;
		logic [7:0]  div;
		logic [6:0]  bitpos;
		logic        bclk;
		logic        fclk;
	} acs_host_s;

	acs_host_s r;
	acs_host_s next_r;
	logic      s_stage;
	logic      req;
	logic      wr;
	logic [2:0] ev;

	acs_sync #(
		.W (1)
	) u_sync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.d       (pins.stage_enable),
		.q       (s_stage)
	);

	assign req = wb_cyc_i && wb_stb_i && !r.ack;
	assign wr = req && wb_we_i && wb_sel_i[0];

	always_comb begin
		next_r = r;
		ev = 3'h0;
		next_r.stage_q = s_stage;
		next_r.ack = req;
		next_r.dat = 32'h0;
		if (r.cnt != '1) begin
			next_r.cnt = r.cnt + 25'h1;
		end
		// reset stays low for the full pulse, covering power-up too
		if (r.state == H_HOLD && r.cnt >= 25'(RST_HOLD_CYCLES - 1)) begin
			next_r.state = H_RUN;
			next_r.reset_n = 1'b1;
			ev[EV_RELEASED] = 1'b1;
		end
		ev[EV_STAGE_UP] = s_stage && !r.stage_q;
		ev[EV_STAGE_DOWN] = !s_stage && r.stage_q;
		if (req && !wb_we_i) begin
			if (wb_adr_i == REG_CTRL) begin
				next_r.dat = {28'h0, r.ctrl_err, r.ctrl_mute, r.ctrl_pdn, r.state == H_HOLD};
			end else if (wb_adr_i == REG_STRAP) begin
				next_r.dat = {27'h0, r.gain_reg, r.fmt_reg};
			end else if (wb_adr_i == REG_STATUS) begin
				next_r.dat = {29'h0, r.status};
			end else if (wb_adr_i == REG_MASK) begin
				next_r.dat = {29'h0, r.mask};
			end
		end
		if (wr && wb_adr_i == REG_CTRL) begin
			next_r.ctrl_pdn = wb_dat_i[CTRL_PDN];
			next_r.ctrl_mute = wb_dat_i[CTRL_MUTE];
			next_r.ctrl_err = wb_dat_i[CTRL_ERR];
			if (wb_dat_i[CTRL_RESET]) begin
				next_r.state = H_HOLD;
				next_r.reset_n = 1'b0;
				next_r.cnt = 25'h0;
			end
		end else if (wr && wb_adr_i == REG_STRAP) begin
			next_r.fmt_reg = wb_dat_i[2:0];
			next_r.gain_reg = wb_dat_i[4:3];
		end else if (wr && wb_adr_i == REG_MASK) begin
			next_r.mask = wb_dat_i[2:0];
		end
		if (wr && wb_adr_i == REG_STATUS) begin
			next_r.status = r.status & ~wb_dat_i[2:0];
		end
		// a new event wins over a clear in the same cycle
		next_r.status = next_r.status | ev;
		next_r.irq = |(next_r.status & r.mask);
		// straps move only while reset is low, right at the start of the pulse
		if (!r.reset_n && r.cnt == 25'h0) begin
			next_r.fmt = r.fmt_reg;
			next_r.gain = r.gain_reg;
		end
		next_r.pdn_cnt = r.pdn_n ? 7'h00 : (r.pdn_cnt == '1 ? r.pdn_cnt : r.pdn_cnt + 7'h01);
		next_r.pdn_n = !(r.ctrl_pdn || (!r.pdn_n && r.pdn_cnt < 7'(PDN_MIN_CYC)));
		next_r.err_cnt = r.err_n ? 6'h00 : (r.err_cnt == '1 ? r.err_cnt : r.err_cnt + 6'h01);
		next_r.err_n = !(r.ctrl_err || (!r.err_n && r.err_cnt < 6'(ERR_MIN_CYC)));
		// bit clock by divider; the frame clock flips on a falling bit edge
		if (r.div >= 8'(HALF_BCLK - 1)) begin
			next_r.div = 8'h00;
			next_r.bclk = !r.bclk;
			if (r.bclk) begin
				if (r.bitpos >= 7'(BITS_PER_FRAME / 2 - 1)) begin
					next_r.bitpos = 7'h00;
					next_r.fclk = !r.fclk;
				end else begin
					next_r.bitpos = r.bitpos + 7'h01;
				end
			end
		end else begin
			next_r.div = r.div + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			r <= '0;
			r.state <= H_HOLD;
			r.pdn_n <= 1'b1;
			r.err_n <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign pins.reset_n          = r.reset_n;
	assign pins.power_down_n     = r.pdn_n;
	assign pins.mute_n           = !r.ctrl_mute;
	assign pins.backend_error_n  = r.err_n;
	assign pins.input_format_sel = r.fmt;
	assign pins.gain_sel         = r.gain;
	assign pins.bclk             = r.bclk;
	assign pins.fclk             = r.fclk;
	assign pins.serial_audio_in  = 1'b0;
	assign wb_dat_o              = r.dat;
	assign wb_ack_o              = r.ack;
	assign irq                   = r.irq;
endmodule // acs_host
`default_nettype wire

// file: acs_if.sv
// pin-level link between the system controller and the amplifier
`timescale 1ns/10ps
`default_nettype none
interface acs_if;
	logic       reset_n;
	logic       power_down_n;
	logic       mute_n;
	logic       backend_error_n;
	logic [2:0] input_format_sel;
	logic [1:0] gain_sel;
	logic       bclk;
	logic       fclk;
	logic       serial_audio_in;
	logic       stage_enable;
	logic       bridge_low;
	modport dev (input reset_n, power_down_n, mute_n, backend_error_n, input_format_sel,
		gain_sel, bclk, fclk, serial_audio_in, output stage_enable, bridge_low);
	modport host (output reset_n, power_down_n, mute_n, backend_error_n, input_format_sel,
		gain_sel, bclk, fclk, serial_audio_in, input stage_enable, bridge_low);
endinterface
`default_nettype wire

// file: acs_pkg.sv
// shared constants and types for the amp control sequencer
`default_nettype none
package acs_pkg;
	localparam int CLK_NS = 10;
	localparam int VALID_LOW_NS = 100;
	localparam int VALID_LOW_CYC = VALID_LOW_NS / CLK_NS;
	localparam real START_MS = 3.6;
	localparam int START_CYC = int'(START_MS * 1.0e6 / CLK_NS);
	localparam int PDN_OFF_US = 725;
	localparam int PDN_OFF_CYC = PDN_OFF_US * 1000 / CLK_NS;
	localparam int PDN_START_US = 650;
	localparam int PDN_START_CYC = PDN_START_US * 1000 / CLK_NS;
	localparam int PDN_MIN_US = 1;
	localparam int PDN_MIN_CYC = (PDN_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int ERR_MIN_NS = 350;
	localparam int ERR_MIN_CYC = (ERR_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int ERR_LOW_NS = 350;
	localparam int ERR_LOW_CYC = ERR_LOW_NS / CLK_NS;
	localparam int ERR_HOLD_MS = 300;
	localparam int ERR_HOLD_CYC = ERR_HOLD_MS * 1000000 / CLK_NS;
	localparam int RST_PULSE_MS = 200;
	localparam int RST_MIN_MS = 100;
	localparam int RST_HOLD_CYC = RST_PULSE_MS * 1000000 / CLK_NS;
	localparam int STRAP_SETUP_US = 100;
	localparam int STRAP_SETUP_CYC = STRAP_SETUP_US * 1000 / CLK_NS;
	localparam int BITS_MIN = 32;
	localparam int BITS_MAX = 64;
	localparam int BCLK_HALF = 4;
	localparam int RAMP_STEPS = 1024;
	localparam logic [4:0] STEP_NORM = 5'h04;
	localparam logic [4:0] STEP_DBL = 5'h08;
	localparam logic [4:0] STEP_QUAD = 5'h10;
	localparam int QUAD_MIN_HZ = 140000;
	localparam int DBL_MIN_HZ = 70000;
	localparam int QUAD_MAX_CYC = 1000000000 / CLK_NS / QUAD_MIN_HZ;
	localparam int DBL_MAX_CYC = 1000000000 / CLK_NS / DBL_MIN_HZ;
	localparam logic [2:0] FMT_RJ16 = 3'h0;
	localparam logic [2:0] FMT_RJ18 = 3'h1;
	localparam logic [2:0] FMT_RJ20 = 3'h2;
	localparam logic [2:0] FMT_RJ24 = 3'h3;
	localparam logic [2:0] FMT_I2S = 3'h4;
	localparam logic [2:0] FMT_LJ = 3'h5;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STRAP = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_MASK = 8'h0c;
	localparam int CTRL_RESET = 0;
	localparam int CTRL_PDN = 1;
	localparam int CTRL_MUTE = 2;
	localparam int CTRL_ERR = 3;
	localparam int EV_RELEASED = 0;
	localparam int EV_STAGE_UP = 1;
	localparam int EV_STAGE_DOWN = 2;
	typedef enum {D_RESET, D_START, D_RUN, D_PDN_DRAIN, D_PDN_OFF, D_PDN_START,
		D_ERR_HOLD, D_ERR_WAIT} acs_dev_e;
	typedef enum {H_HOLD, H_RUN} acs_host_e;
endpackage
`default_nettype wire

// file: acs_sync.sv
// two-stage synchroniser for levels arriving from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module acs_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} acs_sync_s;
	acs_sync_s r;
	acs_sync_s next_r;

	always_comb begin
		next_r = r;
		next_r.s1 = d;
		next_r.s2 = r.s1;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign q = r.s2;
endmodule // acs_sync
`default_nettype wire

// file: tb_top.sv
// self-checking bench: wishbone-driven controller facing the amplifier end
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import acs_pkg::*;
	localparam int RH = 200;
	localparam int ST = 200;
	localparam int PO = 100;
	localparam int PS = 80;
	localparam int EH = 300;
	localparam int BPF = 32;
	localparam int HB = 4;
	logic [3:0]  sel = 4'hf, wsel = 4'hf;
	logic        clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [7:0]  adr = 8'h0;
	logic [31:0] wdat = 32'h0, rdat;
	logic        ack, irq, stage_enable, bridge_low, format_reserved, ratio_ok;
	logic [10:0] volume, last_vol;
	logic [4:0]  gain_db, step_frames;
	logic [2:0]  data_format;
	logic [1:0]  g;
	logic        fclk_d = 1'b0;
	logic [31:0] rd_q[$];
	int mismatches = 0, total_checks = 0, n, frames = 0, dir = 1, nchg = 0;
	bit watch = 0, have = 0;
	always #5 clk = ~clk;
	acs_if lnk();
	acs_host #(.RST_HOLD_CYCLES(RH), .BITS_PER_FRAME(BPF), .HALF_BCLK(HB)) acs_host_i (
		.clk(clk), .sys_rst(sys_rst), .pins(lnk.host), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
		.wb_ack_o(ack), .irq(irq));
	acs_device #(.START_CYCLES(ST), .PDN_OFF_CYCLES(PO), .PDN_START_CYCLES(PS),
		.ERR_HOLD_CYCLES(EH)) acs_device_i (
		.clk(clk), .sys_rst(sys_rst), .pins(lnk.dev), .stage_enable(stage_enable),
		.bridge_low(bridge_low), .volume(volume), .gain_db(gain_db), .data_format(data_format),
		.format_reserved(format_reserved), .ratio_ok(ratio_ok), .step_frames(step_frames));
	acs_checker #(.RST_HOLD_CYCLES(RH), .START_CYCLES(ST), .PDN_OFF_CYCLES(PO),
		.PDN_START_CYCLES(PS), .ERR_HOLD_CYCLES(EH)) acs_checker_i (
		.clk(clk), .sys_rst(sys_rst), .reset_n(lnk.reset_n), .power_down_n(lnk.power_down_n),
		.backend_error_n(lnk.backend_error_n), .input_format_sel(lnk.input_format_sel),
		.gain_sel(lnk.gain_sel), .bclk(lnk.bclk), .fclk(lnk.fclk),
		.stage_enable(lnk.stage_enable), .bridge_low(lnk.bridge_low));
	task automatic print_verdict();
		if (mismatches == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic fail();
		mismatches++;
		$display("MISMATCH %0t wait ran out", $time);
		print_verdict();
	endtask
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check_rng(input int v, input int lo, input int hi);
		total_checks++;
		if (v < lo || v > hi) begin
			mismatches++;
			$display("MISMATCH %0t delay %0d outside %0d..%0d", $time, v, lo, hi);
		end
	endtask
	// classic cycle; the read expectation is queued for the ack monitor
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		int t;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= wsel;
		if (!w) rd_q.push_back(e);
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (ack !== 1'b1 && t < 20);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
		if (t >= 20) fail();
	endtask
	task automatic wait_for(input int sel, input logic v, input int lim, output int t);
		t = 0;
		while (((sel == 0) ? stage_enable : bridge_low) !== v && t < lim) begin
			@(posedge clk);
			t++;
		end
		if (t >= lim) fail();
	endtask
	// the first step after a direction change is partial, so it is never judged
	task automatic ramp(input int d, input int k);
		int t;
		dir = d;
		have = 0;
		nchg = 0;
		watch = 1;
		t = 0;
		while (nchg <= k && t < 30000) begin
			@(posedge clk);
			t++;
		end
		watch = 0;
		if (t >= 30000) fail();
	endtask
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0) check_val(rdat, rd_q.size() ? rd_q.pop_front() : 'x);
	end
	always @(posedge clk) begin
		if (lnk.fclk === 1'b1 && fclk_d === 1'b0) frames++;
		fclk_d = lnk.fclk;
		if (volume !== last_vol) begin
			if (watch && have) begin
				check_val(32'(volume), 32'(last_vol) + 32'(dir));
				check_val(32'(frames), 32'h10);
			end
			have = watch;
			nchg++;
			frames = 0;
			last_vol = volume;
		end
	end
	initial begin
		void'($urandom(32'h6031));
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		wait_for(0, 1'b1, 1000, n);
		wb(1'b1, REG_MASK, 32'h7, 32'h0);
		wb(1'b1, REG_STATUS, 32'h7, 32'h0);
		wb(1'b1, 8'h10, 32'hff, 32'h0);
		wb(1'b0, 8'h10, 32'h0, 32'h0);
		// a write without the low byte lane must leave the register alone
		wsel = {3'($urandom), 1'b0};
		wb(1'b1, REG_MASK, 32'h0, 32'h0);
		wsel = 4'hf;
		wb(1'b0, REG_MASK, 32'h0, 32'h7);
		for (int i = 0; i < 8; i++) begin
			g = 2'($urandom_range(3, 0));
			wb(1'b1, REG_STRAP, {27'h0, g, 3'(i)}, 32'h0);
			wb(1'b1, REG_CTRL, 32'h1, 32'h0);
			wb(1'b0, REG_CTRL, 32'h0, 32'h1);
			wait_for(0, 1'b1, 1000, n);
			check_rng(n, 390, 415);
			check_val(32'(data_format), 32'(i));
			check_val(32'(format_reserved), 32'(i >= 6));
			check_val(32'(gain_db), 32'(g) * 6);
			check_val(32'(bridge_low), 32'h0);
			repeat (5) @(posedge clk);
			check_val(32'(irq), 32'h1);
			wb(1'b0, REG_STATUS, 32'h0, 32'h7);
			wb(1'b1, REG_STATUS, 32'h7, 32'h0);
			repeat (2) @(posedge clk);
			check_val(32'(irq), 32'h0);
		end
		wb(1'b1, REG_MASK, 32'h0, 32'h0);
		wb(1'b1, REG_CTRL, 32'h2, 32'h0);
		wait_for(0, 1'b0, 300, n);
		check_rng(n, 95, 110);
		repeat (5) @(posedge clk);
		check_val(32'(irq), 32'h0);
		wb(1'b1, REG_MASK, 32'h4, 32'h0);
		repeat (2) @(posedge clk);
		check_val(32'(irq), 32'h1);
		wb(1'b1, REG_CTRL, 32'h0, 32'h0);
		wait_for(0, 1'b1, 300, n);
		check_rng(n, 75, 90);
		wb(1'b1, REG_CTRL, 32'h8, 32'h0);
		wait_for(1, 1'b1, 100, n);
		check_rng(n, 0, 35);
		check_val(32'(stage_enable), 32'h0);
		repeat (400) @(posedge clk);
		check_val(32'(bridge_low), 32'h1);
		wb(1'b1, REG_CTRL, 32'h0, 32'h0);
		wait_for(1, 1'b0, 100, n);
		check_rng(n, 0, 40);
		wb(1'b1, REG_CTRL, 32'h8, 32'h0);
		wb(1'b1, REG_CTRL, 32'h0, 32'h0);
		wait_for(1, 1'b1, 100, n);
		wait_for(1, 1'b0, 500, n);
		check_rng(n, 280, 310);
		check_val(32'(stage_enable), 32'h1);
		check_val(32'(ratio_ok), 32'h1);
		check_val(32'(step_frames), 32'h10);
		ramp(1, 3);
		wb(1'b1, REG_CTRL, 32'h4, 32'h0);
		ramp(-1, 2);
		wb(1'b1, REG_CTRL, 32'h0, 32'h0);
		ramp(1, 2);
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
